// *** src/rwcm_defines.svh ***
/*
  Constants for the reset, watchdog and clock monitor block: cycle counts,
  service codes and reset vectors. Assumes a 200 MHz clk_sys used as bus clock.
*/
// Operation
// - any reset aborts the current instruction, initialises state, loads the start vector
// - four sources; power-up and pin share a vector, watchdog and monitor own one each
// - after power-up, hold reset for 4064 internal clock cycles
// - if the pin is still low after that delay, stay in reset until it rises
// - on a sensed reset, drive the reset pin low four bus cycles, then release
// - sample the pin two cycles after release; low means external, high internal
// - an enabled watchdog that expires unserviced starts a system reset
// - watchdog enable comes from a nonvolatile bit, effective only after a reset
// - special modes start with watchdog resets inhibited; writing 0 enables them
// - watchdog clock is bus clock over 2^15, then divided by 1, 4, 16 or 64
// - rate resets to zero; in normal modes one write, only within 64 cycles
// - timer clears only after writing 0x55 then 0xaa to the service register
// - with the monitor enabled, no clock edges within the RC delay start a reset
// - clocks below 10 kHz are failures, 200 kHz or more never are
// - the watchdog stops counting while clocks are halted
// - halting clocks with the monitor enabled produces a reset
// - any reset clears the clock monitor enable
// - watchdog config 0 lets a timeout force reset, 1 blocks it
`ifndef RWCM_DEFINES_SVH
`define RWCM_DEFINES_SVH

`define RWCM_POR_CYCLES     12'd4064
`define RWCM_DRIVE_CYCLES   12'd4
`define RWCM_SAMPLE_CYCLES  12'd2
`define RWCM_SYNC_STAGES    12'd2
`define RWCM_RATE_WINDOW    7'd64
`define RWCM_WDOG_PRESCALE  32768
`define RWCM_SVC_ARM        8'h55
`define RWCM_SVC_CLEAR      8'haa
`define RWCM_CLKMON_FAIL_HZ 10000
`define RWCM_CLKMON_PASS_HZ 200000
`define RWCM_VEC_EXT_NORM   16'hfffe
`define RWCM_VEC_CM_NORM    16'hfffc
`define RWCM_VEC_WD_NORM    16'hfffa
`define RWCM_VEC_EXT_SPEC   16'hbffe
`define RWCM_VEC_CM_SPEC    16'hbffc
`define RWCM_VEC_WD_SPEC    16'hbffa

`endif

// *** src/rwcm_pkg.sv ***
/*
  Types shared by the reset sequencer, its checker and the testbench.
  Assumes nothing beyond the defines header.
*/
package rwcm_pkg;
	typedef enum logic [1:0] {
		CAUSE_EXT,
		CAUSE_CLKMON,
		CAUSE_WDOG
	} rwcm_cause_e;

	typedef enum logic [2:0] {
		ST_POR,
		ST_RUN,
		ST_DRIVE,
		ST_SETTLE,
		ST_HOLD
	} rwcm_state_e;
endpackage

// *** src/rwcm_wd_if.sv ***
/*
  Carrier between the sequencer and the watchdog timer.
  Assumes both ends sit on clk_sys.
*/
`timescale 1ns/1ps
interface rwcm_wd_if;
	logic       clear;
	logic       halted;
	logic [1:0] rate;
	logic       svc_wr;
	logic [7:0] svc_data;
	logic       timeout;

	modport ctl (output clear, output halted, output rate, output svc_wr, output svc_data, input timeout);
	modport wd  (input clear, input halted, input rate, input svc_wr, input svc_data, output timeout);
endinterface

// *** src/rwcm_wdog.sv ***
/*
  Watchdog timer: fixed prescaler, rate divider and two-step service.
  Assumes clear is held through every system reset.
*/
`include "rwcm_defines.svh"
`timescale 1ns/1ps
module rwcm_wdog import rwcm_pkg::*; #(
	parameter int unsigned PRESCALE = `RWCM_WDOG_PRESCALE
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	rwcm_wd_if.wd     w
);
	localparam logic [14:0] PRE_LAST = 15'(PRESCALE - 1);

	logic [14:0] pre;
	logic [6:0]  cnt;
	logic        armed;
	logic        tick;
	logic        serviced;

	// free-running prescaler, frozen with the clocks
	assign tick = (pre == PRE_LAST) && !w.halted;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pre <= 15'h0000;
		end else if (w.clear || tick) begin
			pre <= 15'h0000;
		end else if (!w.halted) begin
			pre <= pre + 15'h0001;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			armed <= 1'b0;
		end else if (w.clear) begin
			armed <= 1'b0;
		end else if (w.svc_wr && w.svc_data == `RWCM_SVC_ARM) begin
			armed <= 1'b1;
		end else if (w.svc_wr && w.svc_data == `RWCM_SVC_CLEAR) begin
			armed <= 1'b0;
		end
	end

	assign serviced = armed && w.svc_wr && w.svc_data == `RWCM_SVC_CLEAR;

	// timeout lands between n and n+1 prescaler periods after a service
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt       <= 7'h00;
			w.timeout <= 1'b0;
		end else begin
			w.timeout <= 1'b0;
			if (w.clear || serviced) begin
				cnt <= 7'h00;
			end else if (tick) begin
				// compare with >= so a lower rate written mid-count still expires
				if (cnt >= 7'(7'h01 << {w.rate, 1'b0})) begin
					cnt       <= 7'h00;
					w.timeout <= 1'b1;
				end else begin
					cnt <= cnt + 7'h01;
				end
			end
		end
	end
endmodule

// *** src/rwcm_top.sv ***
/*
  Reset sequencer with watchdog and clock monitor: power-up delay, reset pin
  drive and sample, cause and vector selection, control bits as plain ports.
  Assumes the reset pin is open drain with a fast pull-up, and an analogue RC
  cell raises clkmon_rc_fail when clk_sys edges stop for its delay.
*/
`include "rwcm_defines.svh"
`timescale 1ns/1ps
module rwcm_top import rwcm_pkg::*; #(
	parameter int unsigned WDOG_PRESCALE = `RWCM_WDOG_PRESCALE
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        rst_pin_in,
	output logic             rst_pin_out,
	output logic             rst_pin_oe,
	input  wire logic        clkmon_rc_fail,
	input  wire logic        special_mode,
	input  wire logic        watchdog_off_cfg,
	input  wire logic        stop_req,
	input  wire logic        clocks_halted,
	input  wire logic        cme_wr,
	input  wire logic        cme_wdata,
	input  wire logic        rate_wr,
	input  wire logic [1:0]  rate_wdata,
	input  wire logic        disable_resets_bit_wr,
	input  wire logic        disable_resets_bit_wdata,
	input  wire logic        watchdog_service_wr,
	input  wire logic [7:0]  watchdog_service_reg,
	output logic             cpu_reset,
	output logic [15:0]      reset_vector,
	output rwcm_cause_e      reset_cause,
	output logic             clk_monitor_enable,
	output logic [1:0]       watchdog_rate_sel,
	output logic             disable_resets_bit,
	output logic             watchdog_enabled
);
	rwcm_wd_if wdi ();

	rwcm_state_e state;
	rwcm_state_e next_state;
	rwcm_cause_e next_cause;
	logic [11:0] cnt;
	logic        cnt_done;
	logic        pin_s1;
	logic        pin_s2;
	logic        cm_set;
	logic        cm_flag;
	logic        cm_s1;
	logic        cm_s2;
	logic        off_lat;
	logic        rate_locked;
	logic [6:0]  win_cnt;
	logic        wd_fire;
	logic        stop_fire;
	logic        start;
	logic [11:0] limit;

	// pin synchroniser; only pin_s2 is read by logic
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
		end else begin
			pin_s1 <= rst_pin_in;
			pin_s2 <= pin_s1;
		end
	end

	// monitor capture must work with clk_sys stopped, so the RC
	// report sets the flag asynchronously; glitches on it only cost a reset
	assign cm_set = clkmon_rc_fail && clk_monitor_enable;

	always_ff @(posedge clk_sys or posedge sys_rst or posedge cm_set) begin
		if (sys_rst) begin
			cm_flag <= 1'b0;
		end else if (cm_set) begin
			cm_flag <= 1'b1;
		end else if (state == ST_DRIVE) begin
			cm_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cm_s1 <= 1'b0;
			cm_s2 <= 1'b0;
		end else begin
			cm_s1 <= cm_flag;
			cm_s2 <= cm_s1;
		end
	end

	// reset sources: watchdog, monitor flag and stop are internal, start also takes the sampled pin
	assign wd_fire   = wdi.timeout && !off_lat && !disable_resets_bit;
	assign stop_fire = stop_req && clk_monitor_enable;
	assign start     = !pin_s2 || wd_fire || cm_s2 || stop_fire;

	always_comb begin
		unique case (state)
			ST_POR:    limit = `RWCM_POR_CYCLES;
			ST_DRIVE:  limit = `RWCM_DRIVE_CYCLES;
			ST_SETTLE: limit = `RWCM_SAMPLE_CYCLES + `RWCM_SYNC_STAGES;
			default:   limit = 12'h001;
		endcase
	end

	// counters hold at their last value until the state moves on
	assign cnt_done = (cnt == limit - 12'h001);

	always_comb begin
		next_state = state;
		next_cause = reset_cause;
		unique case (state)
			ST_POR: begin
				if (cnt_done) begin
					next_state = pin_s2 ? ST_RUN : ST_HOLD;
				end
			end
			ST_RUN: begin
				if (start) begin
					next_state = ST_DRIVE;
					if (!pin_s2) begin
						next_cause = CAUSE_EXT;
					end else if (cm_s2 || stop_fire) begin
						next_cause = CAUSE_CLKMON;
					end else begin
						next_cause = CAUSE_WDOG;
					end
				end
			end
			ST_DRIVE: begin
				if (cnt_done) begin
					next_state = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				// pin_s2 lags the pin by the synchroniser depth
				if (cnt_done) begin
					if (!pin_s2) begin
						next_state = ST_HOLD;
						next_cause = CAUSE_EXT;
					end else begin
						next_state = ST_RUN;
					end
				end
			end
			ST_HOLD: begin
				if (pin_s2) begin
					next_state = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_POR;
			cnt   <= 12'h000;
		end else begin
			state <= next_state;
			if (next_state != state) begin
				cnt <= 12'h000;
			end else if (!cnt_done) begin
				cnt <= cnt + 12'h001;
			end
		end
	end

	// reset output and cause
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cpu_reset <= 1'b1;
		end else begin
			cpu_reset <= (next_state != ST_RUN);
		end
	end

	// cause outlives the reset so software can still tell what happened
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reset_cause <= CAUSE_EXT;
		end else begin
			reset_cause <= next_cause;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reset_vector <= `RWCM_VEC_EXT_NORM;
		end else begin
			unique case (next_cause)
				CAUSE_CLKMON: reset_vector <= special_mode ? `RWCM_VEC_CM_SPEC : `RWCM_VEC_CM_NORM;
				CAUSE_WDOG:   reset_vector <= special_mode ? `RWCM_VEC_WD_SPEC : `RWCM_VEC_WD_NORM;
				default:      reset_vector <= special_mode ? `RWCM_VEC_EXT_SPEC : `RWCM_VEC_EXT_NORM;
			endcase
		end
	end

	// open-drain pin: only ever pulled low
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rst_pin_out <= 1'b0;
		end else begin
			rst_pin_out <= 1'b0;
		end
	end

	// enable is registered so the pin never sees a decode glitch
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rst_pin_oe <= 1'b0;
		end else begin
			rst_pin_oe <= (next_state == ST_DRIVE);
		end
	end

	// nonvolatile enable is only looked at while in reset
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			off_lat <= 1'b1;
		end else if (cpu_reset) begin
			off_lat <= watchdog_off_cfg;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			watchdog_enabled <= 1'b0;
		end else if (cpu_reset) begin
			watchdog_enabled <= !watchdog_off_cfg;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			clk_monitor_enable <= 1'b0;
		end else if (cpu_reset) begin
			clk_monitor_enable <= 1'b0;
		end else if (cme_wr) begin
			clk_monitor_enable <= cme_wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			disable_resets_bit <= 1'b0;
		end else if (!special_mode) begin
			disable_resets_bit <= 1'b0;
		end else if (cpu_reset) begin
			disable_resets_bit <= 1'b1;
		end else if (disable_resets_bit_wr) begin
			disable_resets_bit <= disable_resets_bit_wdata;
		end
	end

	// write-once window for the rate select
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			win_cnt <= 7'h00;
		end else if (cpu_reset) begin
			win_cnt <= 7'h00;
		end else if (win_cnt != `RWCM_RATE_WINDOW) begin
			win_cnt <= win_cnt + 7'h01;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			watchdog_rate_sel <= 2'h0;
		end else if (cpu_reset) begin
			watchdog_rate_sel <= 2'h0;
		end else if (rate_wr) begin
			if (special_mode) begin
				watchdog_rate_sel <= rate_wdata;
			end else if (!rate_locked && win_cnt != `RWCM_RATE_WINDOW) begin
				watchdog_rate_sel <= rate_wdata;
			end
		end
	end

	// the lock only matters in normal modes; special modes rewrite freely
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rate_locked <= 1'b0;
		end else if (cpu_reset) begin
			rate_locked <= 1'b0;
		end else if (rate_wr && !special_mode && win_cnt != `RWCM_RATE_WINDOW) begin
			rate_locked <= 1'b1;
		end
	end

	assign wdi.clear    = cpu_reset;
	assign wdi.halted   = clocks_halted;
	assign wdi.rate     = watchdog_rate_sel;
	assign wdi.svc_wr   = watchdog_service_wr && !cpu_reset;
	assign wdi.svc_data = watchdog_service_reg;

	rwcm_wdog #(
		.PRESCALE (WDOG_PRESCALE)
	) u_wdog (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.w       (wdi.wd)
	);
endmodule

// *** bench/rwcm_top_monitor.sv ***
/*
  checker for the rwcm_top ports: pin drive, pin sample, vectors, control bits.
  assumes binding to every rwcm_top instance.
*/
`timescale 1ns/1ps
module rwcm_top_monitor import rwcm_pkg::*; #(
	parameter int unsigned WDOG_PRESCALE = 16
) (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        rst_pin_in,
	input wire logic        rst_pin_out,
	input wire logic        rst_pin_oe,
	input wire logic        special_mode,
	input wire logic        stop_req,
	input wire logic        cpu_reset,
	input wire logic [15:0] reset_vector,
	input wire rwcm_cause_e reset_cause,
	input wire logic        clk_monitor_enable,
	input wire logic [1:0]  watchdog_rate_sel,
	input wire logic        disable_resets_bit
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence pin_held_low;
		!rst_pin_in [*3] ##0 cpu_reset;
	endsequence
	sequence pin_back_high;
		$fell(rst_pin_oe) ##1 rst_pin_in [*5];
	endsequence
	drive_four_a: assert property ($rose(rst_pin_oe) |-> rst_pin_oe [*4] ##1 !rst_pin_oe)
		else $error("pin drive is not four cycles");
	drive_low_a: assert property (rst_pin_oe |-> !rst_pin_out && cpu_reset)
		else $error("pin drive without reset or high");
	sample_high_a: assert property (pin_back_high |-> ##[0:2] !cpu_reset)
		else $error("reset not left after high sample");
	hold_low_a: assert property (pin_held_low |=> cpu_reset)
		else $error("reset left while pin low");
	ext_start_a: assert property (!rst_pin_in && !rst_pin_oe && !cpu_reset |-> ##[1:5] cpu_reset)
		else $error("external low did not reset");
	stop_reset_a: assert property (stop_req && clk_monitor_enable && !cpu_reset |-> ##[1:3] cpu_reset)
		else $error("stop with monitor on did not reset");
	vector_a: assert property (rst_pin_oe |->
		reset_vector == {special_mode ? 8'hbf : 8'hff, 8'hfe - {5'h0, reset_cause, 1'b0}})
		else $error("vector does not match cause");
	cme_clear_a: assert property ($rose(cpu_reset) |-> ##1 !clk_monitor_enable)
		else $error("monitor enable kept over reset");
	rate_clear_a: assert property ($rose(cpu_reset) |-> ##1 watchdog_rate_sel == 2'h0)
		else $error("rate not cleared by reset");
	disable_resets_bit_normal_a: assert property (!special_mode |-> !disable_resets_bit)
		else $error("reset inhibit set in normal mode");
endmodule

bind rwcm_top rwcm_top_monitor #(.WDOG_PRESCALE(WDOG_PRESCALE)) mon_u (.clk_sys, .sys_rst, .rst_pin_in,
	.rst_pin_out, .rst_pin_oe, .special_mode, .stop_req, .cpu_reset, .reset_vector, .reset_cause,
	.clk_monitor_enable, .watchdog_rate_sel, .disable_resets_bit);

// *** bench/rwcm_ext_rst.sv ***
/*
  external reset circuit: open-drain pin with a fast pull-up and a hold switch.
  assumes rwcm_top drives rst_pin_out and rst_pin_oe.
*/
`timescale 1ns/1ps
module rwcm_ext_rst (
	input  wire logic rst_pin_out,
	input  wire logic rst_pin_oe,
	input  wire logic ext_hold,
	output logic      rst_pin_in
);
	// fast pull-up: the pin is high again well inside two cycles of release
	assign rst_pin_in = ~(rst_pin_oe & ~rst_pin_out) & ~ext_hold;
endmodule

// *** bench/rwcm_top_tb_top.sv ***
/*
  testbench for rwcm_top with the external reset circuit model.
  assumes a short watchdog prescaler of 16 cycles.
*/
`timescale 1ns/1ps
module rwcm_top_tb_top import rwcm_pkg::*;;
	logic        clk_sys, sys_rst, rst_pin_in, rst_pin_out, rst_pin_oe, ext_hold, clkmon_rc_fail;
	logic        special_mode, watchdog_off_cfg, stop_req, clocks_halted, cme_wr, cme_wdata, rate_wr;
	logic        disable_resets_bit_wr, disable_resets_bit_wdata, watchdog_service_wr, cpu_reset, clk_monitor_enable;
	logic        disable_resets_bit, watchdog_enabled;
	logic [1:0]  rate_wdata, watchdog_rate_sel;
	logic [7:0]  watchdog_service_reg;
	logic [15:0] reset_vector;
	rwcm_cause_e reset_cause;
	int          fails, checked, n;

	rwcm_top #(.WDOG_PRESCALE(16)) dut_u (.clk_sys, .sys_rst, .rst_pin_in, .rst_pin_out, .rst_pin_oe,
		.clkmon_rc_fail, .special_mode, .watchdog_off_cfg, .stop_req, .clocks_halted, .cme_wr, .cme_wdata,
		.rate_wr, .rate_wdata, .disable_resets_bit_wr, .disable_resets_bit_wdata, .watchdog_service_wr, .watchdog_service_reg,
		.cpu_reset, .reset_vector, .reset_cause, .clk_monitor_enable, .watchdog_rate_sel,
		.disable_resets_bit, .watchdog_enabled);
	rwcm_ext_rst ext_u (.rst_pin_out, .rst_pin_oe, .ext_hold, .rst_pin_in);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// bounded wait for cpu_reset to reach v; n keeps the cycles spent
	task wait_rst(input logic v, input int lim);
		n = 0;
		while (cpu_reset !== v && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	// 0 monitor enable, 1 rate, 2 inhibit, 3 service, 4 stop, 5 rc flag; idle cycle after so strobes never abut
	task poke(input int k, input logic [7:0] d);
		case (k)
			0: begin cme_wdata = d[0]; cme_wr = 1'b1; end
			1: begin rate_wdata = d[1:0]; rate_wr = 1'b1; end
			2: begin disable_resets_bit_wdata = d[0]; disable_resets_bit_wr = 1'b1; end
			3: begin watchdog_service_reg = d; watchdog_service_wr = 1'b1; end
			4: stop_req = 1'b1;
			default: clkmon_rc_fail = 1'b1;
		endcase
		cyc(1);
		{cme_wr, rate_wr, disable_resets_bit_wr, watchdog_service_wr, stop_req, clkmon_rc_fail} = 6'h00;
		cyc(1);
	endtask
	task tally_and_finish;
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		tally_and_finish();
	end

	initial begin
		{ext_hold, clkmon_rc_fail, special_mode, stop_req, clocks_halted, cme_wr, cme_wdata} = 7'h00;
		{rate_wr, rate_wdata, disable_resets_bit_wr, disable_resets_bit_wdata, watchdog_service_wr, watchdog_service_reg} = 13'h0000;
		fails = 0;
		checked = 0;
		watchdog_off_cfg = 1'b1;
		sys_rst = 1'b1;
		cyc(20);
		sys_rst = 1'b0;
		wait_rst(1'b0, 9000);
		chk(16'(n >= 4064 && n <= 4070), 16'h1);
		chk(16'(watchdog_enabled), 16'h0);
		chk(16'(watchdog_rate_sel), 16'h0);
		poke(1, 8'h03);
		chk(16'(watchdog_rate_sel), 16'h3);
		poke(1, 8'h01);
		chk(16'(watchdog_rate_sel), 16'h3);
		$display("test power-up done");
		poke(5, 8'h00);
		cyc(20);
		chk(16'(cpu_reset), 16'h0);
		poke(0, 8'h01);
		poke(5, 8'h00);
		wait_rst(1'b1, 10);
		chk(16'(reset_cause), 16'(CAUSE_CLKMON));
		chk(reset_vector, 16'hfffc);
		wait_rst(1'b0, 20);
		chk(16'(clk_monitor_enable), 16'h0);
		// the rate window has closed by now, so a late write is refused
		cyc(70);
		poke(1, 8'h02);
		chk(16'(watchdog_rate_sel), 16'h0);
		poke(0, 8'h01);
		poke(4, 8'h00);
		wait_rst(1'b1, 10);
		chk(16'(reset_cause), 16'(CAUSE_CLKMON));
		wait_rst(1'b0, 20);
		$display("test clock monitor done");
		// the new config must wait for a reset; the external hold supplies one
		watchdog_off_cfg = 1'b0;
		cyc(2);
		chk(16'(watchdog_enabled), 16'h0);
		ext_hold = 1'b1;
		cyc(30);
		chk(16'(cpu_reset), 16'h1);
		chk(reset_vector, 16'hfffe);
		ext_hold = 1'b0;
		wait_rst(1'b0, 20);
		chk(16'(watchdog_enabled), 16'h1);
		poke(1, 8'h01);
		$display("test external reset done");
		repeat (6) begin
			cyc(30);
			poke(3, 8'h55);
			poke(3, 8'h33);
			poke(3, 8'haa);
		end
		chk(16'(cpu_reset), 16'h0);
		cyc(40);
		poke(3, 8'haa);
		wait_rst(1'b1, 40);
		chk(16'(cpu_reset), 16'h1);
		chk(reset_vector, 16'hfffa);
		wait_rst(1'b0, 20);
		poke(3, 8'h55);
		poke(3, 8'haa);
		clocks_halted = 1'b1;
		cyc(100);
		chk(16'(cpu_reset), 16'h0);
		clocks_halted = 1'b0;
		wait_rst(1'b1, 40);
		chk(16'(cpu_reset), 16'h1);
		wait_rst(1'b0, 20);
		$display("test watchdog done");
		special_mode = 1'b1;
		sys_rst = 1'b1;
		cyc(20);
		sys_rst = 1'b0;
		wait_rst(1'b0, 9000);
		chk(16'(disable_resets_bit), 16'h1);
		cyc(60);
		chk(16'(cpu_reset), 16'h0);
		poke(2, 8'h00);
		poke(3, 8'h55);
		poke(3, 8'haa);
		wait_rst(1'b1, 40);
		chk(reset_vector, 16'hbffa);
		wait_rst(1'b0, 20);
		// special modes take a rate write long after the window
		cyc(70);
		poke(1, 8'h02);
		chk(16'(watchdog_rate_sel), 16'h2);
		$display("test special mode done");
		tally_and_finish();
	end
endmodule
